// *** pkg/serial_prog_pkg.sv ***
// Shared constants and types for the serial programming read-back block
package serial_prog_pkg;

  // Link framing
  localparam int ADDR_W = 22;
  localparam int CMD_W = 4;
  localparam int OPERAND_BITS = 16;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;
  localparam logic [COUNT_W-1:0] CMD_LAST = 5'h03;
  localparam logic [COUNT_W-1:0] HALF_LAST = 5'h07;
  localparam logic [COUNT_W-1:0] SHIFT_START = 5'h09;
  localparam logic [COUNT_W-1:0] OPERAND_LAST = 5'h0f;

  // Four-bit commands
  localparam logic [CMD_W-1:0] CMD_CORE_INSTR = 4'h0;
  localparam logic [CMD_W-1:0] CMD_SHIFT_OUT_LATCH = 4'h2;
  localparam logic [CMD_W-1:0] CMD_TABLE_READ = 4'h9;

  // Core instruction encodings
  localparam logic [7:0] OP_MOVLW = 8'h0e;
  localparam logic [6:0] OP_MOVWF_TOP = 7'h37;
  localparam logic [5:0] OP_MOVF_TOP = 6'h14;
  localparam logic [3:0] OP_BSF = 4'h8;
  localparam logic [3:0] OP_BCF = 4'h9;

  // Special function register addresses
  localparam logic [7:0] SFR_TABLE_PTR_UPPER = 8'hf8;
  localparam logic [7:0] SFR_TABLE_PTR_HIGH = 8'hf7;
  localparam logic [7:0] SFR_TABLE_PTR_LOW = 8'hf6;
  localparam logic [7:0] SFR_HOLDING_LATCH = 8'hf5;
  localparam logic [7:0] SFR_NVM_CONTROL = 8'ha6;
  localparam logic [7:0] SFR_EEPROM_DATA = 8'ha8;
  localparam logic [7:0] SFR_EEPROM_ADDR_LOW = 8'ha9;
  localparam logic [7:0] SFR_EEPROM_ADDR_HIGH = 8'haa;

  // Nvm control fields
  localparam int PROGRAM_SPACE_BIT = 7;
  localparam int CONFIG_SPACE_BIT = 6;
  localparam int READ_START_BIT = 0;
  localparam logic [7:0] NVM_CONTROL_RESET = 8'h00;

  // Address map
  localparam logic [ADDR_W-1:0] ADDR_ONE = 22'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 22'h000000;
  localparam logic [ADDR_W-1:0] ID_BASE = 22'h200000;
  localparam logic [ADDR_W-1:0] ID_LAST = 22'h200007;
  localparam logic [ADDR_W-1:0] CFG_OSC_HIGH_ADDR = 22'h300001;
  localparam logic [ADDR_W-1:0] CFG_BROWNOUT_LOW_ADDR = 22'h300002;
  localparam logic [ADDR_W-1:0] CFG_WATCHDOG_HIGH_ADDR = 22'h300003;
  localparam logic [ADDR_W-1:0] CFG_CODE_PROT_LOW_ADDR = 22'h300008;
  localparam logic [ADDR_W-1:0] CFG_CODE_PROT_HIGH_ADDR = 22'h300009;
  localparam logic [ADDR_W-1:0] CFG_WRITE_PROT_LOW_ADDR = 22'h30000a;
  localparam logic [ADDR_W-1:0] CFG_WRITE_PROT_HIGH_ADDR = 22'h30000b;
  localparam logic [ADDR_W-1:0] PART_IDENT_LOW_ADDR = 22'h3ffffe;
  localparam logic [ADDR_W-1:0] PART_IDENT_HIGH_ADDR = 22'h3fffff;

  // Protection fields
  localparam int EEPROM_GUARD_BIT = 7;
  localparam int BOOT_GUARD_BIT = 6;
  localparam int EEPROM_LOCK_BIT = 7;
  localparam int BOOT_LOCK_BIT = 6;
  localparam int CONFIG_LOCK_BIT = 5;
  localparam logic [2:0] BLOCK_BOOT = 3'h0;
  localparam logic [2:0] BLOCK_FIRST = 3'h1;
  localparam logic [2:0] BLOCK_NONE = 3'h7;

  // Byte returned by refused or unmapped reads
  localparam logic [7:0] INVALID_READ_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic {SPACE_CODE, SPACE_EEPROM} mem_space_type;
  typedef enum logic {LINK_COMMAND, LINK_OPERAND} link_state_type;

endpackage

// *** hw/two_entry_buffer.sv ***
// Small valid/ready FIFO between the memory answer and the read-back logic
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W:0] COUNT_STEP = (PTR_W + 1)'(1);

  logic [WIDTH-1:0] entry [DEPTH];
  logic [PTR_W-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [PTR_W:0] count, next_count;
  logic push, pop;

  assign inReady = (count != COUNT_FULL);
  assign outValid = (count != '0);
  assign outData = entry[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push) begin
      next_wrPtr = (wrPtr == PTR_LAST) ? '0 : wrPtr + PTR_W'(1);
    end
    if (pop) begin
      next_rdPtr = (rdPtr == PTR_LAST) ? '0 : rdPtr + PTR_W'(1);
    end
    if (push && !pop) begin
      next_count = count + COUNT_STEP;
    end else if (pop && !push) begin
      next_count = count - COUNT_STEP;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage has no reset; entries are only read while counted valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      entry[wrPtr] <= inData;
    end
  end
endmodule // two_entry_buffer

// *** hw/serial_prog_readback.sv ***
// Device-side read-back logic of the two-wire serial programming port
`timescale 1ns/10ps
module serial_prog_readback
  import serial_prog_pkg::*;
#(
  parameter int CODE_BYTES = 65536,
  parameter int BOOT_BYTES = 2048,
  parameter int BLOCK_BYTES = 16384,
  parameter logic [7:0] PART_IDENT_HIGH = 8'h5a, // arbitrary value
  parameter logic [2:0] PART_IDENT_CODE = 3'h5,  // arbitrary value
  parameter logic [4:0] REVISION = 5'h01         // arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Programming pins
  input wire logic progClockPin,
  input wire logic progDataPinIn,
  output logic progDataPinOut,
  output logic progDataPinOe,
  // Nonvolatile read port
  output logic memReq,
  output mem_space_type memSpace,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic memRvalid,
  output logic memRready,
  input wire logic [7:0] memRdata,
  // Configuration bytes from the array
  input wire logic [7:0] oscConfigHigh,
  input wire logic [7:0] brownoutConfigLow,
  input wire logic [7:0] watchdogConfigHigh,
  input wire logic [7:0] codeProtectConfigLow,
  input wire logic [7:0] codeProtectConfigHigh,
  input wire logic [7:0] writeProtectConfigLow,
  input wire logic [7:0] writeProtectConfigHigh,
  // Write permission levels
  output logic [3:0] writeAllowCode,
  output logic writeAllowBoot,
  output logic writeAllowEeprom,
  output logic writeAllowConfig
);
  localparam logic [ADDR_W-1:0] CODE_LAST = ADDR_W'(CODE_BYTES - 1);

  logic clkSync1, clkSync2, clkPrev, datSync1, datSync2;
  logic progClkRise, progClkFall;
  link_state_type linkState, next_linkState;
  logic [COUNT_W-1:0] bitCount, next_bitCount;
  logic [CMD_W-1:0] cmd, next_cmd;
  logic [OPERAND_BITS-1:0] operand, next_operand, word;
  logic [7:0] outShift, next_outShift;
  logic outActive, next_outActive;
  logic [ADDR_W-1:0] tablePtr, next_tablePtr, next_memAddr;
  logic [7:0] holdLatch, next_holdLatch, eepromData, next_eepromData;
  logic [15:0] eepromAddr, next_eepromAddr;
  logic [7:0] nvmControl, next_nvmControl, wreg, next_wreg;
  logic [7:0] fetchByte, next_fetchByte, localByte, sfrValue;
  logic fetchPending, next_fetchPending, next_memReq;
  mem_space_type pendKind, next_pendKind, next_memSpace;
  logic [2:0] lastBlock, next_lastBlock, readBlock;
  logic [4:0] guardVec;
  logic codeRange, idRange, blockGuarded, firstGuarded, eepromGuarded, startRead;
  logic bufOutValid, bufOutReady;
  logic [7:0] bufOutData;

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clkSync1 <= 1'b0;
      clkSync2 <= 1'b0;
      clkPrev <= 1'b0;
      datSync1 <= 1'b0;
      datSync2 <= 1'b0;
    end else begin
      clkSync1 <= progClockPin;
      clkSync2 <= clkSync1;
      clkPrev <= clkSync2;
      datSync1 <= progDataPinIn;
      datSync2 <= datSync1;
    end
  end

  assign progClkRise = clkSync2 && !clkPrev;
  assign progClkFall = !clkSync2 && clkPrev;
  assign word = {datSync2, operand[OPERAND_BITS-1:1]};

  // Protection decode
  assign codeRange = (tablePtr <= CODE_LAST);
  assign idRange = (tablePtr >= ID_BASE) && (tablePtr <= ID_LAST);
  assign readBlock = !codeRange ? BLOCK_NONE :
                     (tablePtr < ADDR_W'(BOOT_BYTES)) ? BLOCK_BOOT :
                     3'(ADDR_W'(BLOCK_FIRST) + tablePtr / ADDR_W'(BLOCK_BYTES));
  assign guardVec = {codeProtectConfigLow[3:0], codeProtectConfigHigh[BOOT_GUARD_BIT]};
  assign blockGuarded = (readBlock != BLOCK_NONE) && !guardVec[readBlock];
  assign firstGuarded = blockGuarded && (readBlock != lastBlock);
  assign eepromGuarded = !codeProtectConfigHigh[EEPROM_GUARD_BIT];
  assign startRead = progClkFall && (linkState == LINK_COMMAND) && (bitCount == CMD_LAST)
                     && (next_cmd == CMD_TABLE_READ);

  // Write permissions
  assign writeAllowCode = writeProtectConfigLow[3:0];
  assign writeAllowBoot = writeProtectConfigHigh[BOOT_LOCK_BIT];
  assign writeAllowEeprom = writeProtectConfigHigh[EEPROM_LOCK_BIT];
  assign writeAllowConfig = writeProtectConfigHigh[CONFIG_LOCK_BIT];

  // Bytes answered without the array
  always_comb begin
    if (tablePtr == CFG_OSC_HIGH_ADDR) begin
      localByte = oscConfigHigh;
    end else if (tablePtr == CFG_BROWNOUT_LOW_ADDR) begin
      localByte = brownoutConfigLow;
    end else if (tablePtr == CFG_WATCHDOG_HIGH_ADDR) begin
      localByte = watchdogConfigHigh;
    end else if (tablePtr == CFG_CODE_PROT_LOW_ADDR) begin
      localByte = codeProtectConfigLow;
    end else if (tablePtr == CFG_CODE_PROT_HIGH_ADDR) begin
      localByte = codeProtectConfigHigh;
    end else if (tablePtr == CFG_WRITE_PROT_LOW_ADDR) begin
      localByte = writeProtectConfigLow;
    end else if (tablePtr == CFG_WRITE_PROT_HIGH_ADDR) begin
      localByte = writeProtectConfigHigh;
    end else if (tablePtr == PART_IDENT_LOW_ADDR) begin
      localByte = {PART_IDENT_CODE, REVISION};
    end else if (tablePtr == PART_IDENT_HIGH_ADDR) begin
      localByte = PART_IDENT_HIGH;
    end else begin
      localByte = INVALID_READ_BYTE;
    end
  end

  // Register file seen by core instructions
  always_comb begin
    if (word[7:0] == SFR_TABLE_PTR_UPPER) begin
      sfrValue = 8'(tablePtr[21:16]);
    end else if (word[7:0] == SFR_TABLE_PTR_HIGH) begin
      sfrValue = tablePtr[15:8];
    end else if (word[7:0] == SFR_TABLE_PTR_LOW) begin
      sfrValue = tablePtr[7:0];
    end else if (word[7:0] == SFR_HOLDING_LATCH) begin
      sfrValue = holdLatch;
    end else if (word[7:0] == SFR_NVM_CONTROL) begin
      sfrValue = nvmControl;
    end else if (word[7:0] == SFR_EEPROM_DATA) begin
      sfrValue = eepromData;
    end else if (word[7:0] == SFR_EEPROM_ADDR_LOW) begin
      sfrValue = eepromAddr[7:0];
    end else if (word[7:0] == SFR_EEPROM_ADDR_HIGH) begin
      sfrValue = eepromAddr[15:8];
    end else begin
      sfrValue = BYTE_ZERO;
    end
  end

  assign bufOutReady = !outActive;

  two_entry_buffer #(.WIDTH(8), .DEPTH(2)) i_two_entry_buffer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inValid(memRvalid),
    .inReady(memRready),
    .inData(memRdata),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  always_comb begin
    next_linkState = linkState;
    next_bitCount = bitCount;
    next_cmd = cmd;
    next_operand = operand;
    next_outShift = outShift;
    next_outActive = outActive;
    next_tablePtr = tablePtr;
    next_holdLatch = holdLatch;
    next_eepromAddr = eepromAddr;
    next_eepromData = eepromData;
    next_nvmControl = nvmControl;
    next_wreg = wreg;
    next_fetchByte = fetchByte;
    next_fetchPending = fetchPending;
    next_pendKind = pendKind;
    next_lastBlock = lastBlock;
    next_memReq = 1'b0;
    next_memAddr = memAddr;
    next_memSpace = memSpace;
    // Array answers, stalled while a byte is on the pin
    if (bufOutValid && bufOutReady) begin
      next_fetchPending = 1'b0;
      if (pendKind == SPACE_EEPROM) begin
        next_eepromData = eepromGuarded ? INVALID_READ_BYTE : bufOutData;
        next_nvmControl[READ_START_BIT] = 1'b0;
      end else begin
        next_fetchByte = bufOutData;
      end
    end
    if (progClkRise && outActive && bitCount >= SHIFT_START) begin
      next_outShift = {1'b0, outShift[7:1]};
    end
    if (progClkFall && linkState == LINK_COMMAND) begin
      next_cmd = {datSync2, cmd[CMD_W-1:1]};
      next_bitCount = bitCount + COUNT_ONE;
      if (bitCount == CMD_LAST) begin
        next_linkState = LINK_OPERAND;
        next_bitCount = '0;
        if (next_cmd == CMD_TABLE_READ) begin
          if (firstGuarded) begin
            next_fetchByte = INVALID_READ_BYTE;
            next_lastBlock = readBlock;
          end else if ((codeRange || idRange) && !fetchPending) begin
            next_memReq = 1'b1;
            next_memAddr = tablePtr;
            next_memSpace = SPACE_CODE;
            next_pendKind = SPACE_CODE;
            next_fetchPending = 1'b1;
            next_lastBlock = readBlock;
          end else begin
            next_fetchByte = localByte;
          end
          next_tablePtr = (tablePtr == CODE_LAST) ? ADDR_ZERO : tablePtr + ADDR_ONE;
        end
      end
    end else if (progClkFall) begin
      next_operand = word;
      next_bitCount = bitCount + COUNT_ONE;
      if (bitCount == HALF_LAST && cmd == CMD_TABLE_READ) begin
        next_outActive = 1'b1;
        next_outShift = fetchByte;
      end else if (bitCount == HALF_LAST && cmd == CMD_SHIFT_OUT_LATCH) begin
        next_outActive = 1'b1;
        next_outShift = holdLatch;
      end
      if (bitCount == OPERAND_LAST) begin
        next_outActive = 1'b0;
        next_linkState = LINK_COMMAND;
        next_bitCount = '0;
        if (cmd == CMD_CORE_INSTR) begin
          if (word[15:8] == OP_MOVLW) begin
            next_wreg = word[7:0];
          end else if (word[15:9] == OP_MOVWF_TOP) begin
            if (word[7:0] == SFR_TABLE_PTR_UPPER) begin
              next_tablePtr[21:16] = wreg[5:0];
            end else if (word[7:0] == SFR_TABLE_PTR_HIGH) begin
              next_tablePtr[15:8] = wreg;
            end else if (word[7:0] == SFR_TABLE_PTR_LOW) begin
              next_tablePtr[7:0] = wreg;
            end else if (word[7:0] == SFR_HOLDING_LATCH) begin
              next_holdLatch = wreg;
            end else if (word[7:0] == SFR_NVM_CONTROL) begin
              next_nvmControl = wreg;
            end else if (word[7:0] == SFR_EEPROM_DATA) begin
              next_eepromData = wreg;
            end else if (word[7:0] == SFR_EEPROM_ADDR_LOW) begin
              next_eepromAddr[7:0] = wreg;
            end else if (word[7:0] == SFR_EEPROM_ADDR_HIGH) begin
              next_eepromAddr[15:8] = wreg;
            end
          end else if (word[15:10] == OP_MOVF_TOP && !word[9]) begin
            next_wreg = sfrValue;
          end else if (word[7:0] == SFR_NVM_CONTROL
                       && (word[15:12] == OP_BSF || word[15:12] == OP_BCF)) begin
            next_nvmControl[word[11:9]] = (word[15:12] == OP_BSF);
          end
          // Read start only reaches the data EEPROM
          if (next_nvmControl[READ_START_BIT] && !nvmControl[READ_START_BIT]) begin
            if (!next_nvmControl[PROGRAM_SPACE_BIT] && !next_nvmControl[CONFIG_SPACE_BIT]
                && !fetchPending) begin
              next_memReq = 1'b1;
              next_memAddr = ADDR_W'(next_eepromAddr);
              next_memSpace = SPACE_EEPROM;
              next_pendKind = SPACE_EEPROM;
              next_fetchPending = 1'b1;
            end else begin
              next_nvmControl[READ_START_BIT] = 1'b0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      linkState <= LINK_COMMAND;
      bitCount <= '0;
      cmd <= '0;
      operand <= WORD_ZERO;
      outShift <= BYTE_ZERO;
      outActive <= 1'b0;
      tablePtr <= ADDR_ZERO;
      holdLatch <= BYTE_ZERO;
      eepromAddr <= WORD_ZERO;
      eepromData <= BYTE_ZERO;
      nvmControl <= NVM_CONTROL_RESET;
      wreg <= BYTE_ZERO;
      fetchByte <= BYTE_ZERO;
      fetchPending <= 1'b0;
      pendKind <= SPACE_CODE;
      lastBlock <= BLOCK_NONE;
      memReq <= 1'b0;
      memAddr <= ADDR_ZERO;
      memSpace <= SPACE_CODE;
    end else begin
      linkState <= next_linkState;
      bitCount <= next_bitCount;
      cmd <= next_cmd;
      operand <= next_operand;
      outShift <= next_outShift;
      outActive <= next_outActive;
      tablePtr <= next_tablePtr;
      holdLatch <= next_holdLatch;
      eepromAddr <= next_eepromAddr;
      eepromData <= next_eepromData;
      nvmControl <= next_nvmControl;
      wreg <= next_wreg;
      fetchByte <= next_fetchByte;
      fetchPending <= next_fetchPending;
      pendKind <= next_pendKind;
      lastBlock <= next_lastBlock;
      memReq <= next_memReq;
      memAddr <= next_memAddr;
      memSpace <= next_memSpace;
    end
  end

  assign progDataPinOut = outShift[0];
  assign progDataPinOe = outActive;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_oe_late_half: assert property (
    progDataPinOe |-> linkState == LINK_OPERAND && bitCount > HALF_LAST)
    else $error("data pin driven outside the last operand half");
  chk_cmd_lsb_first: assert property (
    (progClkFall && linkState == LINK_COMMAND) |=> cmd[CMD_W-1] == $past(datSync2))
    else $error("command bit not shifted in at the top");
  chk_fetch_request: assert property (
    (startRead && codeRange && !firstGuarded && !fetchPending)
    |=> memReq && memAddr == $past(tablePtr) && memSpace == SPACE_CODE)
    else $error("table read did not request the pointed byte");
  chk_ptr_advance: assert property (
    (startRead && tablePtr != CODE_LAST) |=> tablePtr == $past(tablePtr) + ADDR_ONE)
    else $error("table pointer did not advance by one");
  chk_ptr_wrap: assert property (
    (startRead && tablePtr == CODE_LAST) |=> tablePtr == ADDR_ZERO)
    else $error("table pointer did not wrap at code end");
  chk_guard_first_read: assert property (
    (startRead && firstGuarded) |=> fetchByte == INVALID_READ_BYTE && !memReq)
    else $error("first guarded read not refused");
  chk_release_turnaround: assert property (
    (progClkFall && linkState == LINK_OPERAND && bitCount == OPERAND_LAST)
    |=> !progDataPinOe && linkState == LINK_COMMAND ##1 !progDataPinOe)
    else $error("data pin not released after the last operand clock");
  chk_latch_shift_out: assert property (
    (progClkFall && linkState == LINK_OPERAND && bitCount == HALF_LAST
     && cmd == CMD_SHIFT_OUT_LATCH) |=> progDataPinOe && outShift == $past(holdLatch))
    else $error("holding latch not loaded for shift-out");
  chk_movlw_exec: assert property (
    (progClkFall && linkState == LINK_OPERAND && bitCount == OPERAND_LAST
     && cmd == CMD_CORE_INSTR && word[15:8] == OP_MOVLW) |=> wreg == $past(operand[8:1]))
    else $error("literal load not executed");
  chk_eeprom_guard: assert property (
    (bufOutValid && bufOutReady && pendKind == SPACE_EEPROM && eepromGuarded)
    |=> eepromData == INVALID_READ_BYTE)
    else $error("guarded eeprom byte leaked");

  cov_table_read: cover property (startRead ##[1:1000] progDataPinOe);
  cov_ptr_wrap: cover property (startRead && tablePtr == CODE_LAST);
  cov_eeprom_read: cover property (next_memReq && next_memSpace == SPACE_EEPROM);
  cov_buffer_stall: cover property (bufOutValid && !bufOutReady);
endmodule // serial_prog_readback

// *** dv/nv_array_model.sv ***
// Behavioural nonvolatile array answering the read port
`timescale 1ns/10ps
module nv_array_model
  import serial_prog_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Read port
  input wire logic memReq,
  input mem_space_type memSpace,
  input wire logic [ADDR_W-1:0] memAddr,
  output logic memRvalid,
  input wire logic memRready,
  output logic [7:0] memRdata
);
  logic [7:0] reqAddr;
  mem_space_type reqSpace;
  logic [3:0] waitCount;
  logic slow;
  // Alternates prompt and slow answers; data inverted once released
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memRvalid <= 1'b0;
      memRdata <= 8'h00;
      waitCount <= 4'h0;
      slow <= 1'b0;
      reqAddr <= 8'h00;
      reqSpace <= SPACE_CODE;
    end else if (memReq) begin
      reqAddr <= memAddr[7:0];
      reqSpace <= memSpace;
      waitCount <= slow ? 4'h6 : 4'h1;
      slow <= ~slow;
    end else if (waitCount == 4'h1) begin
      memRvalid <= 1'b1;
      memRdata <= (reqSpace == SPACE_EEPROM) ? reqAddr + 8'h11 : reqAddr ^ 8'h3c;
      waitCount <= 4'h0;
    end else if (waitCount != 4'h0) begin
      waitCount <= waitCount - 4'h1;
    end else if (memRvalid && memRready) begin
      memRvalid <= 1'b0;
      memRdata <= ~memRdata;
    end
  end
endmodule // nv_array_model

// *** dv/test_serial_prog_readback.sv ***
// Self-checking bench for the serial programming read-back block
`timescale 1ns/10ps
module test_serial_prog_readback
  import serial_prog_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, progClock = 1'b0, progData = 1'b0;
  logic dOut, dOe, memReq, memRvalid, memRready, allowBoot, allowEeprom, allowConfig;
  mem_space_type memSpace;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memRdata;
  logic [3:0] allowCode;
  logic [7:0] cfg [7] = '{8'h11, 8'h22, 8'h33, 8'hfd, 8'hff, 8'ha5, 8'h60};
  int failures = 0, n_checks = 0, cycles = 0;
  always #2 clk_sys = ~clk_sys;
  serial_prog_readback #(.CODE_BYTES(256), .BOOT_BYTES(16), .BLOCK_BYTES(64))
    i_serial_prog_readback (.clk_sys(clk_sys), .reset_n(reset_n), .progClockPin(progClock),
    .progDataPinIn(progData), .progDataPinOut(dOut), .progDataPinOe(dOe), .memReq(memReq),
    .memSpace(memSpace), .memAddr(memAddr), .memRvalid(memRvalid), .memRready(memRready),
    .memRdata(memRdata), .oscConfigHigh(cfg[0]), .brownoutConfigLow(cfg[1]),
    .watchdogConfigHigh(cfg[2]), .codeProtectConfigLow(cfg[3]), .codeProtectConfigHigh(cfg[4]),
    .writeProtectConfigLow(cfg[5]), .writeProtectConfigHigh(cfg[6]), .writeAllowCode(allowCode),
    .writeAllowBoot(allowBoot), .writeAllowEeprom(allowEeprom), .writeAllowConfig(allowConfig));
  nv_array_model i_nv_array_model (.clk_sys(clk_sys), .reset_n(reset_n), .memReq(memReq),
    .memSpace(memSpace), .memAddr(memAddr), .memRvalid(memRvalid), .memRready(memRready),
    .memRdata(memRdata));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One frame: command then operand, LSB first; read-back sampled while clock high
  task automatic xfer(input logic [3:0] cmd, input logic [15:0] opd, output logic [7:0] rd);
    logic [19:0] bits;
    logic oeBad;
    bits = {opd, cmd};
    oeBad = 1'b0;
    for (int i = 0; i < 20; i++) begin
      // Data moves mid low phase, held well past the fall
      #31.25 progData = bits[i];
      #31.25 progClock = 1'b1;
      #62.5 if (i >= 12) rd[i-12] = dOut;
      oeBad |= (dOe !== (i >= 12 && (cmd == 4'h9 || cmd == 4'h2)));
      progClock = 1'b0;
    end
    #62.5 oeBad |= (dOe !== 1'b0);
    chk8({7'h00, oeBad}, 8'h00);
  endtask
  task automatic ld(input logic [7:0] sfr, input logic [7:0] val);
    logic [7:0] d;
    xfer(4'h0, {OP_MOVLW, val}, d);
    xfer(4'h0, {OP_MOVWF_TOP, 1'b0, sfr}, d);
  endtask
  task automatic ptr(input logic [ADDR_W-1:0] a);
    ld(SFR_TABLE_PTR_UPPER, {2'b00, a[21:16]});
    ld(SFR_TABLE_PTR_HIGH, a[15:8]);
    ld(SFR_TABLE_PTR_LOW, a[7:0]);
  endtask
  task automatic tread(input logic [7:0] exp);
    logic [7:0] d;
    xfer(4'h9, 16'h0000, d);
    chk8(d, exp);
  endtask
  // Two consecutive bytes paired into one code word
  task automatic tword(input logic [15:0] exp);
    logic [7:0] lo, hi;
    xfer(4'h9, 16'h0000, lo);
    xfer(4'h9, 16'h0000, hi);
    chk8(hi, exp[15:8]);
    chk8(lo, exp[7:0]);
  endtask
  task automatic t_guard;
    ptr(22'h000041);
    tread(INVALID_READ_BYTE);
    ptr(22'h000041);
    tread(8'h41 ^ 8'h3c);
    tread(8'h42 ^ 8'h3c);
    tword({8'h44 ^ 8'h3c, 8'h43 ^ 8'h3c});
  endtask
  task automatic t_wrap;
    ptr(22'h0000ff);
    tread(8'hff ^ 8'h3c);
    tread(8'h00 ^ 8'h3c);
    ptr(ID_BASE);
    tread(8'h00 ^ 8'h3c);
    ptr(ID_LAST);
    tread(8'h07 ^ 8'h3c);
  endtask
  task automatic t_ident;
    ptr(PART_IDENT_LOW_ADDR);
    tread(8'ha1);
    tread(8'h5a);
    ptr(CFG_OSC_HIGH_ADDR);
    for (int i = 0; i < 3; i++) tread(cfg[i]);
    ptr(CFG_CODE_PROT_LOW_ADDR);
    for (int i = 3; i < 7; i++) tread(cfg[i]);
  endtask
  task automatic t_eeprom;
    logic [7:0] d;
    for (int g = 0; g < 2; g++) begin
      cfg[4] = {g[0], 7'h7f};
      xfer(4'h0, {OP_BCF, 3'h7, 1'b0, SFR_NVM_CONTROL}, d);
      xfer(4'h0, {OP_BCF, 3'h6, 1'b0, SFR_NVM_CONTROL}, d);
      ld(SFR_EEPROM_ADDR_LOW, 8'h23);
      ld(SFR_EEPROM_ADDR_HIGH, 8'h01);
      xfer(4'h0, {OP_BSF, 3'h0, 1'b0, SFR_NVM_CONTROL}, d);
      xfer(4'h0, {OP_MOVF_TOP, 2'b00, SFR_EEPROM_DATA}, d);
      xfer(4'h0, {OP_MOVWF_TOP, 1'b0, SFR_HOLDING_LATCH}, d);
      xfer(4'h0, WORD_ZERO, d);
      xfer(4'h2, 16'h00ff, d);
      chk8(d, g ? 8'h34 : 8'h00);
    end
    // Read start with program space selected is dropped at once
    xfer(4'h0, {OP_BSF, 3'h7, 1'b0, SFR_NVM_CONTROL}, d);
    xfer(4'h0, {OP_BSF, 3'h0, 1'b0, SFR_NVM_CONTROL}, d);
    xfer(4'h0, {OP_MOVF_TOP, 2'b00, SFR_NVM_CONTROL}, d);
    xfer(4'h0, {OP_MOVWF_TOP, 1'b0, SFR_HOLDING_LATCH}, d);
    xfer(4'h2, 16'h00ff, d);
    chk8(d, 8'h80);
  endtask
  task automatic t_locks;
    #10 chk8({allowCode, allowBoot, allowEeprom, allowConfig, 1'b0}, 8'h5a);
    cfg[5] = 8'h0a;
    cfg[6] = 8'h80;
    #10 chk8({allowCode, allowBoot, allowEeprom, allowConfig, 1'b0}, 8'ha4);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_guard();
    t_wrap();
    t_ident();
    t_eeprom();
    t_locks();
    wrap_up();
  end
endmodule // test_serial_prog_readback
